// file: dv/dbgcmd_far.sv
/*
  Far-side model of the command layer: bus memory and debug firmware.
  Assumes the core's clock and its bus and firmware ports.
*/
`timescale 1ns/1ps
module dbgcmd_far (
  input wire logic clk,
  input wire logic free_en,
  input wire logic steal_go,
  input wire logic [15:0] bus_addr,
  input wire logic fw_req,
  output logic bus_free,
  output logic [15:0] bus_rdata,
  output logic fw_ack,
  output logic [15:0] fw_rdata
);
  logic [2:0] cnt_reg;
  assign bus_free = free_en;
  // Outside the stolen cycle the bus carries other traffic, never the old word
  assign bus_rdata = steal_go ? bus_addr ^ 16'h5a5a : ~(bus_addr ^ 16'h5a5a);
  assign fw_ack = fw_req && cnt_reg == 3'h5;
  assign fw_rdata = fw_ack ? 16'hc3a5 : 16'h3c5a;
  always_ff @(posedge clk)
  begin
    cnt_reg <= fw_req ? cnt_reg + 3'h1 : 3'h0;
  end
endmodule

// file: dv/debug_serial_command_timing_test.sv
/*
  Self-checking bench of the debug command layer with the far-side model.
  Assumes dbgcmd_core and dbgcmd_far are compiled first.
*/
`timescale 1ns/1ps
module debug_serial_command_timing_test;
  logic clk = 0, nrst = 0, cmd_valid = 0, serial_timeout = 0, ext_wait = 0, free_en = 1;
  logic [7:0] cmd_byte = 8'h00;
  logic bus_free, fw_ack, steal_go, bus_we, bus_byte, fw_req, rdata_valid_reg, busy;
  logic [15:0] bus_rdata, fw_rdata, bus_addr, bus_wdata, fw_wdata, rdata_reg;
  logic [7:0] fw_opcode;
  int fail_count = 0, checks = 0, n;
  always #5 clk = ~clk;
  dbgcmd_core u_dut (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .serial_timeout(serial_timeout), .bus_free(bus_free), .ext_wait(ext_wait), .bus_rdata(bus_rdata),
    .steal_go(steal_go), .bus_addr(bus_addr), .bus_we(bus_we), .bus_byte(bus_byte), .bus_wdata(bus_wdata),
    .fw_req(fw_req), .fw_opcode(fw_opcode), .fw_wdata(fw_wdata), .fw_ack(fw_ack), .fw_rdata(fw_rdata),
    .rdata_reg(rdata_reg), .rdata_valid_reg(rdata_valid_reg), .busy(busy));
  dbgcmd_far u_far (.clk(clk), .free_en(free_en), .steal_go(steal_go), .bus_addr(bus_addr),
    .fw_req(fw_req), .bus_free(bus_free), .bus_rdata(bus_rdata), .fw_ack(fw_ack), .fw_rdata(fw_rdata));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [7:0] b);
    @(negedge clk);
    cmd_valid = 1;
    cmd_byte = b;
    @(negedge clk);
    cmd_valid = 0;
  endtask
  // Returns the number of falling edges waited
  task automatic wait_hi(ref logic s, output int k);
    k = 0;
    #1;
    while (s !== 1'b1)
    begin
      @(negedge clk);
      #1;
      k++;
      if (k > 300)
      begin
        fail_count++;
        $display("[FAIL] handshake expected 1 seen %b", s);
        stop_test();
      end
    end
  endtask
  task automatic hw_read(input logic [7:0] opc, input logic [15:0] a, input logic [15:0] ea);
    send(opc);
    send(a[15:8]);
    send(a[7:0]);
    wait_hi(steal_go, n);
    chk("read address", ea, bus_addr);
    chk("read byte flag", {15'h0, opc[3]}, {15'h0, bus_byte});
    @(negedge clk);
    chk("read valid", 16'h1, {15'h0, rdata_valid_reg});
    chk("read word", ea ^ 16'h5a5a, rdata_reg);
    repeat (150) @(negedge clk);
    $display("hw read %h at %h done", opc, a);
  endtask
  task automatic hw_write_wait;
    free_en = 0;
    ext_wait = 1;
    {n} = 0;
    send(8'hc0);
    send(8'h12);
    send(8'h35);
    send(8'hab);
    send(8'hcd);
    repeat (140) @(negedge clk) n += int'(steal_go);
    chk("steal under wait", 16'h0, n[15:0]);
    ext_wait = 0;
    #1;
    chk("steal after wait", 16'h1, {15'h0, steal_go});
    chk("write address", 16'h1234, bus_addr);
    chk("write data", 16'habcd, bus_wdata);
    chk("write flag", 16'h1, {15'h0, bus_we});
    repeat (150) @(negedge clk);
    send(8'hc8);
    send(8'h00);
    send(8'h11);
    send(8'h22);
    send(8'h33);
    wait_hi(steal_go, n);
    chk("forced steal bound", 16'h1, {15'h0, n >= 100 && n <= 127});
    chk("byte write address", 16'h0011, bus_addr);
    repeat (150) @(negedge clk);
    free_en = 1;
    $display("hw write and wait done");
  endtask
  task automatic fw_cmds;
    send(8'h40);
    send(8'h56);
    send(8'h78);
    wait_hi(fw_req, n);
    chk("fw opcode", 16'h0040, {8'h00, fw_opcode});
    chk("fw write data", 16'h5678, fw_wdata);
    repeat (36) @(negedge clk);
    send(8'h00);
    wait_hi(rdata_valid_reg, n);
    chk("fw read word", 16'hc3a5, rdata_reg);
    repeat (48) @(negedge clk);
    $display("fw commands done");
  endtask
  task automatic abort_run;
    ext_wait = 1;
    send(8'h80);
    send(8'h12);
    send(8'h34);
    @(negedge clk);
    // Steal and time-out fall in the same cycle
    ext_wait = 0;
    serial_timeout = 1;
    @(negedge clk);
    serial_timeout = 0;
    n = 0;
    repeat (20) @(negedge clk) n += int'(steal_go | busy);
    chk("steal after time-out", 16'h0, n[15:0]);
    chk("valid after time-out", 16'h0, {15'h0, rdata_valid_reg});
    $display("time-out abort done");
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    nrst = 1;
    hw_read(8'h80, 16'h1235, 16'h1234);
    hw_read(8'h88, 16'h1235, 16'h1235);
    hw_read(8'h88, 16'h1234, 16'h1234);
    hw_write_wait();
    fw_cmds();
    abort_run();
    stop_test();
  end
endmodule

// file: hw/dbgcmd_core.sv
/*
  Command layer of the background_debug_port: frames opcode, address and
  data bytes, steals bus cycles for hardware commands and hands firmware
  commands to the debug firmware, and returns 16-bit read data.
  Assumes the serial bit layer runs on clk and delivers whole bytes.
*/
//
// Contract
// - A command is an 8-bit opcode followed, by kind, by a 16-bit address, a 16-bit data word, both, or nothing for a firmware read.
// - Every read returns a 16-bit value, byte or word access alike.
// - A byte read leaves its byte in the upper half for an even address and the lower half for an odd one.
// - A misaligned word access by a hardware command drops address bit 0 and uses the even address.
// - The wait for a free bus cycle lasts at most 128 cycles, inside the 150-cycle allowance.
// - No cycle is stolen while an external bus wait is applied, so the counts hold only without it.
// - A serial time-out soft-resets the command layer, which may lose a delayed access.
`timescale 1ns/1ps
`include "dbgcmd_map.svh"

module dbgcmd_core (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic serial_timeout,
  input wire logic bus_free,
  input wire logic ext_wait,
  input wire logic [15:0] bus_rdata,
  output logic steal_go,
  output logic [15:0] bus_addr,
  output logic bus_we,
  output logic bus_byte,
  output logic [15:0] bus_wdata,
  output logic fw_req,
  output logic [7:0] fw_opcode,
  output logic [15:0] fw_wdata,
  input wire logic fw_ack,
  input wire logic [15:0] fw_rdata,
  output logic [15:0] rdata_reg,
  output logic rdata_valid_reg,
  output logic busy
);

  dbgcmd_pkg::dbgcmd_state_t state_reg;
  dbgcmd_pkg::dbgcmd_state_t state_next;
  logic [7:0] opcode_reg;
  logic [15:0] addr_reg;
  logic [15:0] data_reg;
  logic [6:0] wait_cnt_reg;
  logic is_hw;
  logic is_wr;
  logic is_byte;
  logic fw_done;

  assign is_hw = opcode_reg[`DBGCMD_OPC_HW_BIT];
  assign is_wr = opcode_reg[`DBGCMD_OPC_WR_BIT];
  assign is_byte = opcode_reg[`DBGCMD_OPC_BYTE_BIT];
  assign busy = (state_reg == dbgcmd_pkg::DBGCMD_STEAL) || (state_reg == dbgcmd_pkg::DBGCMD_FW);

  // Forced steal after the last wait cycle, never during an external wait
  assign steal_go = (state_reg == dbgcmd_pkg::DBGCMD_STEAL) && !ext_wait
                    && (bus_free || (wait_cnt_reg == `DBGCMD_STEAL_LAST));
  assign fw_req = (state_reg == dbgcmd_pkg::DBGCMD_FW);
  assign fw_done = fw_req && fw_ack;
  assign bus_addr = addr_reg;
  assign bus_wdata = data_reg;
  assign bus_we = is_wr;
  assign bus_byte = is_byte;
  assign fw_opcode = opcode_reg;
  assign fw_wdata = data_reg;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      dbgcmd_pkg::DBGCMD_IDLE:
        if (cmd_valid)
        begin
          if (cmd_byte[`DBGCMD_OPC_HW_BIT])
            state_next = dbgcmd_pkg::DBGCMD_ADDR_HI;
          else if (cmd_byte[`DBGCMD_OPC_WR_BIT])
            state_next = dbgcmd_pkg::DBGCMD_DATA_HI;
          else
            state_next = dbgcmd_pkg::DBGCMD_FW;
        end
      dbgcmd_pkg::DBGCMD_ADDR_HI:
        if (cmd_valid)
          state_next = dbgcmd_pkg::DBGCMD_ADDR_LO;
      dbgcmd_pkg::DBGCMD_ADDR_LO:
        if (cmd_valid)
          state_next = is_wr ? dbgcmd_pkg::DBGCMD_DATA_HI : dbgcmd_pkg::DBGCMD_STEAL;
      dbgcmd_pkg::DBGCMD_DATA_HI:
        if (cmd_valid)
          state_next = dbgcmd_pkg::DBGCMD_DATA_LO;
      dbgcmd_pkg::DBGCMD_DATA_LO:
        if (cmd_valid)
          state_next = is_hw ? dbgcmd_pkg::DBGCMD_STEAL : dbgcmd_pkg::DBGCMD_FW;
      dbgcmd_pkg::DBGCMD_STEAL:
        if (steal_go)
          state_next = dbgcmd_pkg::DBGCMD_IDLE;
      dbgcmd_pkg::DBGCMD_FW:
        if (fw_ack)
          state_next = dbgcmd_pkg::DBGCMD_IDLE;
      default:
        state_next = dbgcmd_pkg::DBGCMD_IDLE;
    endcase
    // Time-out wins over everything; a stalled access is dropped
    if (serial_timeout)
      state_next = dbgcmd_pkg::DBGCMD_IDLE;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_reg <= dbgcmd_pkg::DBGCMD_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      opcode_reg <= `DBGCMD_BYTE_RST;
    else if (state_reg == dbgcmd_pkg::DBGCMD_IDLE && cmd_valid && !serial_timeout)
      opcode_reg <= cmd_byte;
  end

  // Word accesses are forced even when the low address byte arrives
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      addr_reg <= `DBGCMD_WORD_RST;
    else if (cmd_valid && state_reg == dbgcmd_pkg::DBGCMD_ADDR_HI)
      addr_reg <= {cmd_byte, addr_reg[7:0]};
    else if (cmd_valid && state_reg == dbgcmd_pkg::DBGCMD_ADDR_LO)
      addr_reg <= {addr_reg[15:8], cmd_byte[7:1], cmd_byte[0] & is_byte};
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      data_reg <= `DBGCMD_WORD_RST;
    else if (cmd_valid && state_reg == dbgcmd_pkg::DBGCMD_DATA_HI)
      data_reg <= {cmd_byte, data_reg[7:0]};
    else if (cmd_valid && state_reg == dbgcmd_pkg::DBGCMD_DATA_LO)
      data_reg <= {data_reg[15:8], cmd_byte};
  end

  // Saturates so a long external wait still leaves a bounded forced steal
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      wait_cnt_reg <= 7'h00;
    else if (state_reg != dbgcmd_pkg::DBGCMD_STEAL)
      wait_cnt_reg <= 7'h00;
    else if (wait_cnt_reg != `DBGCMD_STEAL_LAST)
      wait_cnt_reg <= wait_cnt_reg + 7'h01;
  end

  // Whole bus word kept: even byte sits high, odd byte sits low
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_reg <= `DBGCMD_WORD_RST;
    else if (steal_go && !is_wr)
      rdata_reg <= bus_rdata;
    else if (fw_done && !is_wr)
      rdata_reg <= fw_rdata;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_valid_reg <= 1'b0;
    // Time-out beats a read landing in the same cycle: rdata_reg still loads but is not flagged valid
    else if (serial_timeout)
      rdata_valid_reg <= 1'b0;
    else if ((steal_go || fw_done) && !is_wr)
      rdata_valid_reg <= 1'b1;
    else if (state_reg == dbgcmd_pkg::DBGCMD_IDLE && cmd_valid)
      rdata_valid_reg <= 1'b0;
  end

  opcode_frame_a: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == dbgcmd_pkg::DBGCMD_IDLE && cmd_valid && cmd_byte[7] && !serial_timeout
    |=> state_reg == dbgcmd_pkg::DBGCMD_ADDR_HI)
    else $error("Hardware opcode not followed by address");

  write_frame_a: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == dbgcmd_pkg::DBGCMD_ADDR_LO && cmd_valid && is_wr && !serial_timeout
    |=> state_reg == dbgcmd_pkg::DBGCMD_DATA_HI)
    else $error("Write address not followed by data");

  read_width_a: assert property (@(posedge clk) disable iff (!nrst)
    steal_go && !is_wr && !serial_timeout |=> rdata_valid_reg && rdata_reg == $past(bus_rdata))
    else $error("Read word not returned whole");

  fw_read_word_a: assert property (@(posedge clk) disable iff (!nrst)
    fw_done && !is_wr && !serial_timeout |=> rdata_valid_reg && rdata_reg == $past(fw_rdata))
    else $error("Firmware read word not returned whole");

  byte_lane_a: assert property (@(posedge clk) disable iff (!nrst)
    steal_go && !is_wr && is_byte && bus_addr[0] |=> rdata_reg[7:0] == $past(bus_rdata[7:0]))
    else $error("Odd byte not in lower half");

  even_lane_a: assert property (@(posedge clk) disable iff (!nrst)
    steal_go && !is_wr && is_byte && !bus_addr[0] |=> rdata_reg[15:8] == $past(bus_rdata[15:8]))
    else $error("Even byte not in upper half");

  word_align_a: assert property (@(posedge clk) disable iff (!nrst)
    steal_go && !is_byte |-> !bus_addr[0])
    else $error("Word access at odd address");

  steal_bound_a: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == dbgcmd_pkg::DBGCMD_STEAL && wait_cnt_reg == 7'h7f && !ext_wait |-> steal_go)
    else $error("No steal after the longest wait");

  ext_wait_a: assert property (@(posedge clk) disable iff (!nrst)
    ext_wait |-> !steal_go)
    else $error("Cycle stolen during external wait");

  timeout_reset_a: assert property (@(posedge clk) disable iff (!nrst)
    serial_timeout |=> state_reg == dbgcmd_pkg::DBGCMD_IDLE && !rdata_valid_reg)
    else $error("Time-out did not reset the port");

endmodule

// file: hw/dbgcmd_map.svh
/*
  Constants of the debug command layer: opcode fields, cycle counts.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef DBGCMD_MAP_SVH
`define DBGCMD_MAP_SVH

// Opcode fields
`define DBGCMD_OPC_HW_BIT 7
`define DBGCMD_OPC_WR_BIT 6
`define DBGCMD_OPC_BYTE_BIT 3

// Bus clock rate and host allowances, in bus cycles
`define DBGCMD_CLK_MHZ 100
`define DBGCMD_HW_HOST_WAIT 150
`define DBGCMD_FW_RD_HOST_WAIT 48
`define DBGCMD_FW_WR_HOST_WAIT 36
`define DBGCMD_STRETCH_MAX 7

// Longest wait for a free cycle before a forced steal
`define DBGCMD_STEAL_MAX 128
`define DBGCMD_STEAL_LAST 7'h7f

// Reset values
`define DBGCMD_WORD_RST 16'h0000
`define DBGCMD_BYTE_RST 8'h00

`endif

// file: hw/dbgcmd_pkg.sv
/*
  Types of the debug command layer.
  Assumes dbgcmd_map.svh is on the include path.
*/
`include "dbgcmd_map.svh"

package dbgcmd_pkg;

  typedef enum logic [6:0] {
    DBGCMD_IDLE = 7'b0000001,
    DBGCMD_ADDR_HI = 7'b0000010,
    DBGCMD_ADDR_LO = 7'b0000100,
    DBGCMD_DATA_HI = 7'b0001000,
    DBGCMD_DATA_LO = 7'b0010000,
    DBGCMD_STEAL = 7'b0100000,
    DBGCMD_FW = 7'b1000000
  } dbgcmd_state_t;

endpackage
